// *** rtl/tsense_pkg.sv ***
// register map, field positions, reset values and timing for the sensor block
// assumes a 50 MHz system clock and a serial link clocked by the bus clock pin
`default_nettype none
package tsense_pkg;
  // register slots selected by the command byte
  localparam logic [7:0]  REG_CAP      = 8'h00;
  localparam logic [7:0]  REG_CFG      = 8'h01;
  localparam logic [7:0]  REG_UPPER    = 8'h02;
  localparam logic [7:0]  REG_LOWER    = 8'h03;
  localparam logic [7:0]  REG_CRIT     = 8'h04;
  localparam logic [7:0]  REG_TEMP     = 8'h05;
  localparam logic [7:0]  REG_MAKER    = 8'h06;
  localparam logic [7:0]  REG_PART     = 8'h07;
  localparam logic [7:0]  REG_SPARE_LO = 8'h08;
  localparam logic [7:0]  REG_SPARE_HI = 8'h0e;
  // reset values
  localparam logic [15:0] CAP_RESET    = 16'h0017;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [3:0]  CFG_RESET    = 4'h0;
  // configuration bit positions
  localparam int          CFG_MODE     = 0;
  localparam int          CFG_POL      = 1;
  localparam int          CFG_CRIT_ONLY = 2;
  localparam int          CFG_EN       = 3;
  localparam int          CFG_STATUS   = 4;
  localparam int          CFG_CLEAR    = 5;
  // fixed upper part of the slave address
  localparam logic [3:0]  ADDR_PREFIX  = 4'h3;
  // conversion timing
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          CONV_PERIOD_MS = 125;
  localparam int          CONV_CYCLES  = CONV_PERIOD_MS * (CLK_HZ / 1000);
  localparam int          TICK_W       = 23;
  // link engine states
  typedef enum logic [3:0] {
    L_IDLE = 4'b0000,
    L_ADDR = 4'b0001,
    L_ACKA = 4'b0010,
    L_CMD  = 4'b0011,
    L_ACKC = 4'b0100,
    L_WDAT = 4'b0101,
    L_ACKW = 4'b0110,
    L_RDAT = 4'b0111,
    L_ACKR = 4'b1000
  } link_st_t;
endpackage
`default_nettype wire

// *** rtl/tsense_link.sv ***
// two-wire slave byte engine, clocked by the bus clock pin
// assumes the master keeps the data line stable while the bus clock is high
`default_nettype none
module tsense_link
  import tsense_pkg::*;
(
  input  wire logic        i_scl,
  input  wire logic        i_rst_b,
  input  wire logic        i_sda,
  input  wire logic        i_addr_select_bit0,
  input  wire logic        i_addr_select_bit1,
  input  wire logic        i_addr_select_bit2,
  input  wire logic [15:0] i_snap,
  output logic             o_sda_oe,
  output logic [7:0]       o_ptr,
  output logic [15:0]      o_wdata,
  output logic             o_wr_tog,
  output logic             o_cmd_tog
);
  import tsense_pkg::*;

  typedef struct packed {
    link_st_t    st;
    logic [2:0]  bitcnt;
    logic [7:0]  sh;
    logic [7:0]  txsh;
    logic        rw;
    logic        lo;
    logic [7:0]  ptr;
    logic [7:0]  hi;
    logic [15:0] wdata;
    logic        wr_tog;
    logic        cmd_tog;
    logic        start_seen;
    logic [2:0]  asel_s1;
    logic [2:0]  asel_s2;
  } link_t;

  link_t q;
  link_t n;
  logic  start_tog;
  logic  sda_oe_q;
  logic  oe_want;
  logic [7:0] rx;

  // start: data falls while the bus clock is high
  always_ff @(negedge i_sda or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_tog <= 1'b0;
    end else if (i_scl) begin
      start_tog <= ~start_tog;
    end
  end

  // byte sequencing on each rising bus clock
  always_comb begin
    n = q;
    rx = {q.sh[6:0], i_sda};
    n.start_seen = start_tog;
    n.asel_s1 = {i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0};
    n.asel_s2 = q.asel_s1;
    if (q.start_seen != start_tog) begin
      n.st = L_ADDR;
      n.sh = rx;
      n.bitcnt = 3'd1;
    end else begin
      case (q.st)
        L_ADDR, L_CMD, L_WDAT: begin
          n.sh = rx;
          n.bitcnt = q.bitcnt + 3'd1;
          if (q.bitcnt == 3'd7) begin
            if (q.st == L_ADDR) begin
              if (rx[7:1] == {ADDR_PREFIX, q.asel_s2}) begin // R2
                n.st = L_ACKA;
                n.rw = rx[0]; // R3
              end else begin
                n.st = L_IDLE; // R28
              end
            end else if (q.st == L_CMD) begin
              n.ptr = rx; // R7
              n.cmd_tog = ~q.cmd_tog;
              n.st = L_ACKC;
            end else begin
              if (!q.lo) begin
                n.hi = rx; // R5
              end else begin
                n.wdata = {q.hi, rx}; // R7
                n.wr_tog = ~q.wr_tog;
              end
              n.st = L_ACKW;
            end
          end
        end
        L_ACKA: begin
          n.bitcnt = 3'd0;
          n.lo = 1'b0;
          n.st = q.rw ? L_RDAT : L_CMD; // R3
          n.txsh = i_snap[15:8]; // R9
        end
        L_ACKC: begin
          n.bitcnt = 3'd0;
          n.lo = 1'b0;
          n.st = L_WDAT;
        end
        L_ACKW: begin
          n.bitcnt = 3'd0;
          n.lo = 1'b1;
          n.st = q.lo ? L_IDLE : L_WDAT; // R5
        end
        L_RDAT: begin
          n.txsh = {q.txsh[6:0], 1'b0};
          n.bitcnt = q.bitcnt + 3'd1;
          if (q.bitcnt == 3'd7) begin
            n.st = L_ACKR;
          end
        end
        L_ACKR: begin
          n.bitcnt = 3'd0;
          if (!i_sda && !q.lo) begin
            n.st = L_RDAT;
            n.lo = 1'b1;
            n.txsh = i_snap[7:0]; // R9
          end else begin
            n.st = L_IDLE;
          end
        end
        default: n.st = L_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // data line is pulled only in ack slots and for zero read bits
  always_comb begin
    oe_want = (q.st == L_ACKA) || (q.st == L_ACKC) || (q.st == L_ACKW); // R4
    if (q.st == L_RDAT) begin
      oe_want = ~q.txsh[7]; // R9
    end
  end

  // drive changes only while the bus clock is low
  always_ff @(negedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= oe_want; // R27
    end
  end

  assign o_sda_oe  = sda_oe_q;
  assign o_ptr     = q.ptr;
  assign o_wdata   = q.wdata;
  assign o_wr_tog  = q.wr_tog;
  assign o_cmd_tog = q.cmd_tog;
endmodule
`default_nettype wire

// *** rtl/tsense_top.sv ***
// temperature sensor digital core: register file, conversion tick and alert pin
// assumes a converter result on the system clock and a two-wire bus on its own clock
// Operation
// R1 - latched temperature refreshes eight times a second, readable any time
// R2 - answer only address 0011 followed by select bits two, one, zero
// R3 - direction bit zero writes, one reads
// R4 - every received byte is acknowledged low on its ninth clock
// R5 - registers are sixteen bits, moved as two bytes, high first
// R6 - master writes: start, address, command, high, low, stop
// R7 - command byte selects register; write data lands there
// R8 - master reads: command, repeated start, read address, ack high, nack low
// R9 - read data leaves high byte first, most significant bit first
// R10 - reset loads capability 0017h and zero everywhere else; the maker and part slots read MAKER_ID and PART_ID instead
// R11 - slots 08h to 0Eh read as zero
// R12 - configuration bit one picks the alert active level
// R13 - alert released while configuration bit three is zero
// R14 - alert triggers on entering or leaving the alarm window
// R15 - reaching critical asserts alert until temperature falls below it
// R16 - comparator style follows out-of-window, unaffected by register access
// R17 - comparator alert drops once temperature is back inside window
// R18 - interrupt style asserts per crossing; clear drops it
// R19 - after clear, critical reasserts; clear ignored above critical
// R20 - clear while above critical takes effect on falling below critical
// R21 - without clear, interrupt alert stays after leaving critical
// R22 - three alert styles: comparator, interrupt, critical-only
// R23 - configuration bit zero: zero comparator, one interrupt
// R24 - configuration bit two set: alert only above critical
// R25 - clear at bit five is write-only, reads zero, interrupt only
// R26 - bit four reads whether alert is asserted, ignoring polarity
// R27 - data line released except ack slots and driven read bits
// R28 - foreign address is not acknowledged; rest of transfer ignored
`default_nettype none
module tsense_top
  import tsense_pkg::*;
#(
  parameter int          CONV_TICKS = CONV_CYCLES,
  parameter logic [15:0] MAKER_ID   = 16'h0a5a, // arbitrary value
  parameter logic [15:0] PART_ID    = 16'h0101  // arbitrary value
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_scl,
  input  wire logic        i_sda_in,
  input  wire logic        i_addr_select_bit0,
  input  wire logic        i_addr_select_bit1,
  input  wire logic        i_addr_select_bit2,
  input  wire logic [15:0] i_temp_sample,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output logic             o_event_out,
  output logic             o_event_oe
);
  import tsense_pkg::*;

  typedef struct packed {
    logic [3:0]        cfg;
    logic [15:0]       upper;
    logic [15:0]       lower;
    logic [15:0]       crit;
    logic [15:0]       temp;
    logic [TICK_W-1:0] tick_cnt;
    logic              int_flag;
    logic              clr_pend;
    logic              outside_prev;
    logic              above_prev;
    logic              evt;
    logic              ev_oe;
    logic              drv_low;
    logic [2:0]        wr_sync;
    logic [2:0]        cmd_sync;
    logic [15:0]       snap;
  } core_t;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CONV_TICKS - 1);

  core_t       s_q;
  core_t       s_d;
  logic [7:0]  link_ptr;
  logic [15:0] link_wdata;
  logic        link_wr_tog;
  logic        link_cmd_tog;
  logic        wr_edge;
  logic        cmd_edge;
  logic        outside;
  logic        above;
  logic        int_mode;
  logic        set_now;
  logic        clr_now;

  // serial link in the bus clock domain
  tsense_link u_link (
    .i_scl              (i_scl),
    .i_rst_b            (i_rst_b),
    .i_sda              (i_sda_in),
    .i_addr_select_bit0 (i_addr_select_bit0),
    .i_addr_select_bit1 (i_addr_select_bit1),
    .i_addr_select_bit2 (i_addr_select_bit2),
    .i_snap             (s_q.snap),
    .o_sda_oe           (o_sda_oe),
    .o_ptr              (link_ptr),
    .o_wdata            (link_wdata),
    .o_wr_tog           (link_wr_tog),
    .o_cmd_tog          (link_cmd_tog)
  );

  // read mux over the register slots
  function automatic logic [15:0] read_word(input core_t r, input logic [7:0] p);
    logic [15:0] w;
    w = WORD_RESET;
    case (p)
      REG_CAP:   w = CAP_RESET; // R10
      REG_CFG: begin
        w[3:0] = r.cfg;
        w[CFG_STATUS] = r.evt; // R26
        w[CFG_CLEAR] = 1'b0; // R25
      end
      REG_UPPER: w = r.upper;
      REG_LOWER: w = r.lower;
      REG_CRIT:  w = r.crit;
      REG_TEMP:  w = r.temp; // R1
      REG_MAKER: w = MAKER_ID;
      REG_PART:  w = PART_ID;
      default:   w = WORD_RESET; // R11
    endcase
    return w;
  endfunction

  // window and critical comparisons on signed readings
  always_comb begin
    outside  = ($signed(s_q.temp) > $signed(s_q.upper)) ||
               ($signed(s_q.temp) < $signed(s_q.lower)); // R14
    above    = $signed(s_q.temp) >= $signed(s_q.crit); // R15
    int_mode = s_q.cfg[CFG_MODE]; // R23
    wr_edge  = s_q.wr_sync[2] ^ s_q.wr_sync[1];
    cmd_edge = s_q.cmd_sync[2] ^ s_q.cmd_sync[1];
    set_now  = (outside != s_q.outside_prev) || (above && !s_q.above_prev); // R18
    clr_now  = wr_edge && (link_ptr == REG_CFG) && link_wdata[CFG_CLEAR] && int_mode; // R25
  end

  // next state of the core
  always_comb begin
    s_d = s_q;
    s_d.drv_low = 1'b0;
    s_d.wr_sync = {s_q.wr_sync[1:0], link_wr_tog};
    s_d.cmd_sync = {s_q.cmd_sync[1:0], link_cmd_tog};
    s_d.outside_prev = outside;
    s_d.above_prev = above;
    // conversion tick, eight per second by default
    if (s_q.tick_cnt == TICK_LAST) begin
      s_d.tick_cnt = '0;
      s_d.temp = i_temp_sample; // R1
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end
    // committed word writes from the link
    if (wr_edge) begin
      case (link_ptr)
        REG_CFG:   s_d.cfg = link_wdata[3:0]; // R7
        REG_UPPER: s_d.upper = link_wdata;
        REG_LOWER: s_d.lower = link_wdata;
        REG_CRIT:  s_d.crit = link_wdata;
        default:   s_d.cfg = s_q.cfg;
      endcase
    end
    // snapshot for the next read, taken when the command byte lands
    if (cmd_edge) begin
      s_d.snap = read_word(s_q, link_ptr); // R9
    end
    // interrupt-style latch with deferred clear above critical
    if (clr_now && above) begin
      s_d.clr_pend = 1'b1; // R20
    end
    // crossing critical from a cleared state drops again once below critical
    if (int_mode && above && !s_q.above_prev && !s_q.int_flag) begin
      s_d.clr_pend = 1'b1; // R19
    end
    if (clr_now && !above) begin
      s_d.int_flag = 1'b0; // R18
      s_d.clr_pend = 1'b0;
    end
    if (s_q.clr_pend && s_q.above_prev && !above) begin
      s_d.int_flag = 1'b0; // R20
      s_d.clr_pend = 1'b0;
    end
    if (!int_mode) begin
      s_d.clr_pend = 1'b0;
    end
    if (set_now) begin
      s_d.int_flag = 1'b1; // R19
    end
    if (above && s_q.int_flag && !set_now && !s_q.clr_pend) begin
      s_d.int_flag = 1'b1; // R21
    end
    // style select and enable
    if (s_q.cfg[CFG_CRIT_ONLY]) begin
      s_d.evt = s_q.cfg[CFG_EN] && above; // R24
    end else if (int_mode) begin
      s_d.evt = s_q.cfg[CFG_EN] && s_d.int_flag; // R22
    end else begin
      s_d.evt = s_q.cfg[CFG_EN] && (outside || above); // R16 R17
    end
    // open-drain pin pulls low for the active-low asserted or active-high idle level
    if (!s_q.cfg[CFG_EN]) begin
      s_d.ev_oe = 1'b0; // R13
    end else if (s_q.cfg[CFG_POL]) begin
      s_d.ev_oe = !s_q.evt; // R12
    end else begin
      s_d.ev_oe = s_q.evt; // R12
    end
  end

  // core registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0; // R10
    end else begin
      s_q <= s_d;
    end
  end

  assign o_event_oe  = s_q.ev_oe;
  assign o_event_out = s_q.drv_low;
  assign o_sda_out   = s_q.drv_low;

  // checks on the core
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_TEMP_HOLD: assert property ( // R1
    (s_q.tick_cnt != TICK_LAST) |=> $stable(s_q.temp))
    else $error("temperature changed without a tick");

  AST_CAP_READ: assert property ( // R10
    (cmd_edge && link_ptr == REG_CAP) |=> (s_q.snap == CAP_RESET))
    else $error("capability word wrong");

  AST_SPARE_ZERO: assert property ( // R11
    (cmd_edge && link_ptr >= REG_SPARE_LO && link_ptr <= REG_SPARE_HI) |=> (s_q.snap == WORD_RESET))
    else $error("spare slot not zero");

  AST_CFG_READ: assert property ( // R26
    (cmd_edge && link_ptr == REG_CFG) |=>
      (!s_q.snap[CFG_CLEAR] && s_q.snap[CFG_STATUS] == $past(s_q.evt)))
    else $error("configuration readback wrong");

  AST_DISABLED: assert property ( // R13
    !s_q.cfg[CFG_EN] |=> !o_event_oe)
    else $error("alert driven while disabled");

  AST_POLARITY: assert property ( // R12
    (s_q.cfg[CFG_EN] && s_q.cfg[CFG_POL]) |=> (o_event_oe == !$past(s_q.evt)))
    else $error("active-high level wrong");

  AST_COMPARATOR: assert property ( // R16
    (!int_mode && !s_q.cfg[CFG_CRIT_ONLY] && s_q.cfg[CFG_EN]) |=> (s_q.evt == $past(outside || above)))
    else $error("comparator alert wrong");

  AST_CRIT_ONLY: assert property ( // R24
    (s_q.cfg[CFG_CRIT_ONLY] && s_q.cfg[CFG_EN]) |=> (s_q.evt == $past(above)))
    else $error("critical-only alert wrong");

  AST_INT_CLEAR: assert property ( // R18
    (clr_now && !above && !set_now) |=> !s_q.int_flag)
    else $error("clear did not drop interrupt alert");

  AST_INT_PEND: assert property ( // R20
    (int_mode && s_q.clr_pend && s_q.above_prev && !above && !set_now) |=> !s_q.int_flag)
    else $error("deferred clear lost");

  AST_INT_CRIT: assert property ( // R19
    (int_mode && above && !s_q.above_prev) |=> s_q.int_flag ##1 s_q.evt || !s_q.cfg[CFG_EN])
    else $error("critical crossing did not reassert");

  COV_TEMP_READ: cover property (cmd_edge && link_ptr == REG_TEMP);
  COV_CFG_WRITE: cover property (wr_edge && link_ptr == REG_CFG);
  COV_DEFER:     cover property (s_q.clr_pend ##[1:1000] !s_q.int_flag);
  COV_ALERT:     cover property ($rose(o_event_oe));
endmodule
`default_nettype wire

// *** verif/tsense_bus_master.sv ***
// behavioural two-wire bus master driving the sensor's bus clock and data line
// assumes the data input is the resolved wired-AND level with a pull-up
`default_nettype none
module tsense_bus_master (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe,
  output logic      o_clash
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles with clock high and data released
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
    o_clash  = 1'b0;
  end

  // one 80 ns bus clock: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, input logic own, output logic r);
    #20 o_sda_oe <= !b;
    #20 o_scl <= 1'b1;
    #20 r = i_sda;
    if (own && b && !r) o_clash <= 1'b1; // a released bit pulled low by the device
    #20 o_scl <= 1'b0;
  endtask

  // start or repeated start: data falls while clock high
  task automatic start_cond();
    #27 o_sda_oe <= 1'b0; // odd delay keeps bus edges off the system clock edges
    #20 o_scl <= 1'b1;
    #20 o_sda_oe <= 1'b1;
    #20 o_scl <= 1'b0;
  endtask

  // stop: data rises while clock high, bus left idle
  task automatic stop_cond();
    #20 o_sda_oe <= 1'b1;
    #20 o_scl <= 1'b1;
    #20 o_sda_oe <= 1'b0;
    #20;
  endtask

  // clock pulses with data high, no start, so the address straps settle
  task automatic idle_clocks();
    repeat (2) begin
      #40 o_scl <= 1'b0;
      #40 o_scl <= 1'b1;
    end
  endtask

  // eight bits msb first, then the ninth clock released for the ack
  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], 1'b1, r);
    end
    bit_io(1'b1, 1'b0, ack);
  endtask

  // eight bits read msb first, then our ack or nack
  task automatic byte_in(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, 1'b0, v[i]);
    end
    bit_io(nack, 1'b1, r);
  endtask

  // word write: start, address+0, command, high, low, stop
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                            output logic [3:0] acks);
    start_cond();
    byte_out({a, 1'b0}, acks[3]);
    byte_out(c, acks[2]);
    byte_out(d[15:8], acks[1]);
    byte_out(d[7:0], acks[0]);
    stop_cond();
  endtask

  // word read: command written, repeated start, address+1, ack high, nack low
  task automatic read_word(input logic [6:0] a, input logic [7:0] c, output logic [2:0] acks,
                           output logic [15:0] d);
    start_cond();
    byte_out({a, 1'b0}, acks[2]);
    byte_out(c, acks[1]);
    start_cond();
    byte_out({a, 1'b1}, acks[0]);
    byte_in(1'b0, d[15:8]);
    byte_in(1'b1, d[7:0]);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// *** verif/test_temp_sensor_twowire_event.sv ***
// self-checking bench for the sensor core: register map, addressing and alert styles
// assumes the bus master model for the link and a short conversion period
`default_nettype none
module test_temp_sensor_twowire_event;
  timeunit 1ns;
  timeprecision 100ps;
  import tsense_pkg::*;

  localparam int          TICKS = 40;
  localparam logic [15:0] MAKER = 16'h0c3c; // arbitrary value
  localparam logic [15:0] PART  = 16'h0202; // arbitrary value
  localparam logic [6:0]  DEV   = {ADDR_PREFIX, 3'b101};

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] first;
    logic [15:0] wdata;
    logic [15:0] after;
  } row_t;

  logic        i_clk;
  logic        i_rst_b;
  logic [15:0] temp;
  logic        scl;
  logic        m_oe;
  logic        clash;
  logic        dev_out;
  logic        dev_oe;
  logic        ev_out;
  logic        ev_oe;
  wire logic   sda;
  int          errors;
  int          samples_checked;

  // read before write, write, read after
  row_t rows [11] = '{
    '{REG_CAP,      16'h0017, 16'hffff, 16'h0017},
    '{REG_CFG,      16'h0000, 16'h0020, 16'h0000},
    '{REG_UPPER,    16'h0000, 16'h1234, 16'h1234},
    '{REG_LOWER,    16'h0000, 16'h8001, 16'h8001},
    '{REG_CRIT,     16'h0000, 16'h7fff, 16'h7fff},
    '{REG_TEMP,     16'h0190, 16'hffff, 16'h0190},
    '{REG_MAKER,    MAKER,    16'h0000, MAKER},
    '{REG_PART,     PART,     16'hffff, PART},
    '{REG_SPARE_LO, 16'h0000, 16'hffff, 16'h0000},
    '{REG_SPARE_HI, 16'h0000, 16'hffff, 16'h0000},
    '{8'h0f,        16'h0000, 16'hffff, 16'h0000}
  };

  // wired-AND data line with pull-up
  assign sda = !(m_oe | dev_oe);

  tsense_top #(.CONV_TICKS(TICKS), .MAKER_ID(MAKER), .PART_ID(PART)) tsense_top_i (
    .i_clk              (i_clk),
    .i_rst_b            (i_rst_b),
    .i_scl              (scl),
    .i_sda_in           (sda),
    .i_addr_select_bit0 (1'b1),
    .i_addr_select_bit1 (1'b0),
    .i_addr_select_bit2 (1'b1),
    .i_temp_sample      (temp),
    .o_sda_out          (dev_out),
    .o_sda_oe           (dev_oe),
    .o_event_out        (ev_out),
    .o_event_oe         (ev_oe)
  );

  tsense_bus_master tsense_bus_master_i (
    .i_sda    (sda),
    .o_scl    (scl),
    .o_sda_oe (m_oe),
    .o_clash  (clash)
  );

  // system clock, 20 ns
  initial i_clk = 1'b0;
  always #10 i_clk = !i_clk;

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input logic [3:0] ea);
    logic [3:0] acks;
    tsense_bus_master_i.write_word(a, c, d, acks);
    check_word("write acks", {12'h000, ea}, {12'h000, acks});
  endtask

  task automatic rd_check(input logic [7:0] c, input logic [15:0] exp);
    logic [2:0]  acks;
    logic [15:0] d;
    tsense_bus_master_i.read_word(DEV, c, acks, d);
    check_word("read acks", 16'h0000, {13'h0000, acks});
    check_word("read data", exp, d);
  endtask

  // allow one conversion tick plus the alert pipeline to settle
  task automatic ev(input logic exp_oe);
    repeat (TICKS + 4) @(posedge i_clk);
    @(negedge i_clk);
    check_bit("event drive", exp_oe, ev_oe);
  endtask

  // new converter result, wait past one tick, then read it back over the bus
  task automatic set_temp(input logic [15:0] v);
    @(posedge i_clk);
    temp <= v;
    repeat (TICKS + 4) @(posedge i_clk);
    rd_check(REG_TEMP, v);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    errors++;
    $display("mismatch watchdog expected done seen running");
    give_verdict();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    temp = 16'h0190;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    check_bit("event drive in reset", 1'b0, ev_oe);
    tsense_bus_master_i.idle_clocks();
    // ordinary register cases
    for (int k = 0; k < 11; k++) begin
      rd_check(rows[k].cmd, rows[k].first);
      wr(DEV, rows[k].cmd, rows[k].wdata, 4'h0);
      rd_check(rows[k].cmd, rows[k].after);
    end
    // foreign select bits and foreign prefix
    wr({ADDR_PREFIX, 3'b100}, REG_UPPER, 16'h5555, 4'hf);
    wr({4'h7, 3'b101}, REG_UPPER, 16'h5555, 4'hf);
    rd_check(REG_UPPER, 16'h1234);
    // comparator style, active low, then active high and back
    wr(DEV, REG_CFG, 16'h0008, 4'h0);
    ev(1'b0);
    set_temp(16'h2000);
    ev(1'b1);
    rd_check(REG_CFG, 16'h0018);
    ev(1'b1);
    wr(DEV, REG_CFG, 16'h000a, 4'h0);
    ev(1'b0);
    rd_check(REG_CFG, 16'h001a);
    wr(DEV, REG_CFG, 16'h0008, 4'h0);
    wr(DEV, REG_UPPER, 16'h7000, 4'h0);
    ev(1'b0);
    wr(DEV, REG_UPPER, 16'h1234, 4'h0);
    ev(1'b1);
    // interrupt style
    wr(DEV, REG_CRIT, 16'h3000, 4'h0);
    wr(DEV, REG_CFG, 16'h0009, 4'h0);
    wr(DEV, REG_CFG, 16'h0029, 4'h0);
    ev(1'b0);
    rd_check(REG_CFG, 16'h0009);
    set_temp(16'h0190);
    ev(1'b1);
    wr(DEV, REG_CFG, 16'h0029, 4'h0);
    ev(1'b0);
    set_temp(16'h2000);
    ev(1'b1);
    wr(DEV, REG_CFG, 16'h0029, 4'h0);
    ev(1'b0);
    set_temp(16'h3500);
    ev(1'b1);
    wr(DEV, REG_CFG, 16'h0029, 4'h0);
    ev(1'b1);
    set_temp(16'h2000);
    ev(1'b0);
    set_temp(16'h3500);
    ev(1'b1);
    set_temp(16'h2000);
    ev(1'b0);
    set_temp(16'h0190);
    ev(1'b1);
    set_temp(16'h3500);
    ev(1'b1);
    set_temp(16'h2000);
    ev(1'b1);
    wr(DEV, REG_CFG, 16'h0029, 4'h0);
    ev(1'b0);
    // critical-only style
    wr(DEV, REG_CFG, 16'h000c, 4'h0);
    ev(1'b0);
    set_temp(16'h3500);
    ev(1'b1);
    set_temp(16'h2000);
    ev(1'b0);
    // disabled output stays released
    set_temp(16'h3500);
    wr(DEV, REG_CFG, 16'h0004, 4'h0);
    ev(1'b0);
    // reset in mid-run
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    tsense_bus_master_i.idle_clocks();
    rd_check(REG_CFG, 16'h0000);
    rd_check(REG_CRIT, 16'h0000);
    check_bit("data line clash", 1'b0, clash);
    check_bit("sda drive value", 1'b0, dev_out);
    check_bit("event drive value", 1'b0, ev_out);
    give_verdict();
  end
endmodule
`default_nettype wire
